// >>> core/nvac_ctrl.sv
// Top of the nvm access controller: I/O registers, programming timer,
// core stall and ready interrupt request
// Assumes I/O accesses are one-cycle strobes from the core on clock_i
`timescale 1ns/1ps
`include "nvac_defines.svh"

// Operation
// - Mode field selects atomic, erase, or write
// - Mode writes ignored while programming
// - Reset clears mode unless still programming
// - Ready interrupt enable gated by global enable
// - Ready request holds while memory idle
// - Unlock bit clears four cycles later
// - Program strobe acts only while unlocked
// - Program strobe reads busy, hardware clears
// - Program start stalls core two cycles
// - Read strobe loads data immediately
// - Read stalls core four cycles
// - No read or address change while busy
// - Data register feeds writes, receives reads
// - Linear addressing, unused address bits zero
// - Small variant reads address bit seven zero
// - Control bits seven and six read zero
// - Data, enables, strobes reset to zero
// - Top address bit in high register
// - Write without erase leaves byte lost
// - Reset never aborts running programming
module nvac_ctrl #(
   parameter int MEM_BYTES = 512,
   parameter int CLK_HZ = `NVAC_CLK_HZ,
   parameter int ATOMIC_CYCLES = int'((64'(CLK_HZ) * `NVAC_T_ATOMIC_US) / 1000000),
   parameter int SPLIT_CYCLES = int'((64'(CLK_HZ) * `NVAC_T_SPLIT_US) / 1000000)
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [5:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic global_irq_en_i,
   output logic [7:0] io_rdata_o,
   output logic ready_irq_o,
   output logic core_stall_o
);
   localparam int AW = $clog2(MEM_BYTES);
   localparam int CW = $clog2(ATOMIC_CYCLES + 1);

   // Refuse sizes and timings the logic cannot serve
   if (MEM_BYTES != 128 && MEM_BYTES != 256 && MEM_BYTES != 512) begin : g_bad_size
      $error("MEM_BYTES must be 128, 256 or 512");
   end
   if (SPLIT_CYCLES < 1 || ATOMIC_CYCLES < SPLIT_CYCLES) begin : g_bad_time
      $error("programming cycle counts invalid");
   end

   // Place the address bits of the memory into a 9-bit word
   function automatic logic [8:0] addr_word(input logic [AW-1:0] a);
      addr_word = 9'(a);
   endfunction

   ////////////////////////////////////////////////////////////////
   // Registers
   nvac_pkg::nvac_state_t state;
   nvac_pkg::nvac_mode_t mode;
   logic [AW-1:0] addr;
   logic [7:0] data;
   logic rdy_ie;
   logic unlock;
   logic [2:0] unlock_cnt;
   logic [CW-1:0] prog_cnt;
   logic [CW-1:0] prog_len;
   nvac_pkg::nvac_mode_t run_mode;
   logic [7:0] prog_data;

   ////////////////////////////////////////////////////////////////
   // Access decode
   wire sel_ctrl = io_addr_i == `NVAC_OFS_CONTROL;
   wire sel_data = io_addr_i == `NVAC_OFS_DATA;
   wire sel_alo = io_addr_i == `NVAC_OFS_ADDR_LOW;
   wire sel_ahi = io_addr_i == `NVAC_OFS_ADDR_HIGH;
   wire wr_ctrl = io_wr_i && sel_ctrl;
   wire busy = state != nvac_pkg::NVAC_IDLE;
   wire prog_req = wr_ctrl && io_wdata_i[`NVAC_BIT_PROG];
   wire prog_go = prog_req && unlock && !busy
                  && mode != nvac_pkg::NVAC_MODE_RSVD;
   wire read_go = wr_ctrl && io_wdata_i[`NVAC_BIT_READ] && !busy;
   wire unlock_set = wr_ctrl && io_wdata_i[`NVAC_BIT_UNLOCK];
   wire prog_done = state == nvac_pkg::NVAC_PROG && prog_cnt == prog_len;

   // Cycle count for the selected mode
   assign prog_len = (mode == nvac_pkg::NVAC_MODE_ATOMIC) ?
                     CW'(ATOMIC_CYCLES) : CW'(SPLIT_CYCLES);

   ////////////////////////////////////////////////////////////////
   // Memory array and its action strobes at the end of programming
   logic [7:0] mem_rdata;
   wire do_erase = prog_done && run_mode != nvac_pkg::NVAC_MODE_WRITE;
   wire do_write = prog_done && run_mode != nvac_pkg::NVAC_MODE_ERASE;

   nvac_array #(
      .DEPTH(MEM_BYTES),
      .AW(AW)
   ) u_array (
      .clock_i(clock_i),
      .addr_i(addr),
      .wdata_i(prog_data),
      .erase_i(do_erase),
      .write_i(do_write),
      .rdata_o(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////
   // Core stall after read and program starts
   nvac_stall u_stall (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .read_go_i(read_go),
      .prog_go_i(prog_go),
      .stall_o(core_stall_o)
   );

   ////////////////////////////////////////////////////////////////
   // Programming sequencer; reset does not stop a running operation
   always_ff @(posedge clock_i) begin
      if (!rst_n_i && !busy) begin
         state <= nvac_pkg::NVAC_IDLE;
         prog_cnt <= '0;
         run_mode <= nvac_pkg::NVAC_MODE_ATOMIC;
      end else begin
         unique case (state)
            nvac_pkg::NVAC_IDLE: begin
               if (prog_go) begin
                  state <= nvac_pkg::NVAC_PROG;
                  run_mode <= mode;
                  prog_data <= data;                           // Byte fixed at start
                  prog_cnt <= CW'(1);
               end
            end
            nvac_pkg::NVAC_PROG: begin
               if (prog_done) begin
                  state <= nvac_pkg::NVAC_DONE;
               end else begin
                  prog_cnt <= prog_cnt + CW'(1);
               end
            end
            nvac_pkg::NVAC_DONE: begin
               state <= nvac_pkg::NVAC_IDLE;
            end
            // Unused code or unknown power-up state falls back to idle
            default: begin
               state <= nvac_pkg::NVAC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Mode field, held across reset while busy
   always_ff @(posedge clock_i) begin
      if (!rst_n_i && !busy) begin
         mode <= nvac_pkg::nvac_mode_t'(`NVAC_RST_MODE);
      end else if (wr_ctrl && !busy && !prog_req) begin
         mode <= nvac_pkg::nvac_mode_t'(io_wdata_i[`NVAC_BIT_MODE_HI:`NVAC_BIT_MODE_LO]);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Unlock bit with four-cycle expiry
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         unlock <= 1'b0;
         unlock_cnt <= 3'h0;
      end else if (unlock_set) begin
         unlock <= 1'b1;
         unlock_cnt <= 3'(`NVAC_UNLOCK_CYCLES);
      end else if (unlock_cnt != 3'h0) begin
         unlock_cnt <= unlock_cnt - 3'h1;
         unlock <= unlock_cnt != 3'h1;
      end else begin
         unlock <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Data, address and interrupt enable registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         data <= `NVAC_RST_DATA;
         rdy_ie <= 1'b0;
      end else begin
         if (read_go) begin
            data <= mem_rdata;
         end else if (io_wr_i && sel_data) begin
            data <= io_wdata_i;
         end
         if (wr_ctrl) begin
            rdy_ie <= io_wdata_i[`NVAC_BIT_RDY_IE];
         end
      end
   end

   // Address has no reset; frozen while busy
   always_ff @(posedge clock_i) begin
      if (io_wr_i && sel_alo && !busy) begin
         addr[AW > 8 ? 7 : AW-1:0] <= io_wdata_i[AW > 8 ? 7 : AW-1:0];
      end else if (io_wr_i && sel_ahi && !busy && AW > 8) begin
         addr[AW-1] <= io_wdata_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read-back mux
   wire [8:0] addr_full = addr_word(addr);
   wire [7:0] ctrl_view = {2'b00, mode, rdy_ie, unlock, busy, 1'b0};
   wire [7:0] next_rdata = sel_ctrl ? ctrl_view :
                           sel_data ? data :
                           sel_alo ? addr_full[7:0] :
                           sel_ahi ? {7'h00, addr_full[8]} : 8'h00;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         io_rdata_o <= 8'h00;
         ready_irq_o <= 1'b0;
      end else begin
         io_rdata_o <= io_rd_i ? next_rdata : 8'h00;
         ready_irq_o <= rdy_ie && global_irq_en_i && !busy && !prog_go;
      end
   end
endmodule

// >>> core/nvac_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the nvm access controller files only
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH

// I/O register offsets
`define NVAC_OFS_CONTROL 6'h1c
`define NVAC_OFS_DATA 6'h1d
`define NVAC_OFS_ADDR_LOW 6'h1e
`define NVAC_OFS_ADDR_HIGH 6'h1f

// Control register field positions
`define NVAC_BIT_READ 0
`define NVAC_BIT_PROG 1
`define NVAC_BIT_UNLOCK 2
`define NVAC_BIT_RDY_IE 3
`define NVAC_BIT_MODE_LO 4
`define NVAC_BIT_MODE_HI 5

// Reset values
`define NVAC_RST_DATA 8'h00
`define NVAC_RST_MODE 2'h0

// Timing
`define NVAC_CLK_HZ 25000000
`define NVAC_T_ATOMIC_US 3400
`define NVAC_T_SPLIT_US 1800
`define NVAC_UNLOCK_CYCLES 4
`define NVAC_PROG_STALL 2
`define NVAC_READ_STALL 4

`endif

// >>> core/nvac_pkg.sv
// Types shared by the nvm access controller
// Assumes the defines header is compiled alongside
package nvac_pkg;
   typedef enum logic [1:0] {
      NVAC_MODE_ATOMIC = 2'h0,
      NVAC_MODE_ERASE = 2'h1,
      NVAC_MODE_WRITE = 2'h2,
      NVAC_MODE_RSVD = 2'h3
   } nvac_mode_t;
   typedef enum logic [1:0] {
      NVAC_IDLE,
      NVAC_PROG,
      NVAC_DONE
   } nvac_state_t;
endpackage

// >>> core/nvac_stall.sv
// Core stall generator for read and program starts
// Assumes one-cycle start pulses from the same clock
`timescale 1ns/1ps
`include "nvac_defines.svh"

module nvac_stall (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic read_go_i,
   input wire logic prog_go_i,
   output logic stall_o
);
   logic [2:0] count;
   logic [2:0] next_count;

   ////////////////////////////////////////////////////////////////
   // Load the hold length, count it down
   assign next_count = read_go_i ? 3'(`NVAC_READ_STALL) :
                       prog_go_i ? 3'(`NVAC_PROG_STALL) :
                       (count != 3'h0) ? count - 3'h1 : 3'h0;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         count <= 3'h0;
         stall_o <= 1'b0;
      end else begin
         count <= next_count;
         stall_o <= (next_count != 3'h0);
      end
   end
endmodule

// >>> core/nvac_array.sv
// Byte array of the nonvolatile data memory with erase and write
// Assumes one operation at a time; atomic mode asserts erase and write together
`timescale 1ns/1ps

module nvac_array #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clock_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic erase_i,
   input wire logic write_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH];

   // Refuse a depth that the address cannot reach
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("DEPTH does not fit the address width");
   end

   ////////////////////////////////////////////////////////////////
   // Erase sets all ones; write only clears bits, so an unerased
   // location ends up as the AND of old and new contents
   always_ff @(posedge clock_i) begin
      if (erase_i && write_i) begin
         mem[addr_i] <= wdata_i;
      end else if (erase_i) begin
         mem[addr_i] <= 8'hff;
      end else if (write_i) begin
         mem[addr_i] <= mem[addr_i] & wdata_i;
      end
   end

   // Combinational read so data lands in one access
   assign rdata_o = mem[addr_i];
endmodule

// >>> verif/nvac_checker.sv
// Port checker for the nvm access controller
// Assumes a bind into nvac_ctrl; read data is valid one cycle after the strobe
`timescale 1ns/1ps
module nvac_checker #(
   parameter int ATOMIC_CYCLES = 20,
   parameter int SPLIT_CYCLES = 10
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [5:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic global_irq_en_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic ready_irq_o,
   input wire logic core_stall_o
);
   localparam int A_QUIET = ATOMIC_CYCLES - 2;
   localparam int S_QUIET = SPLIT_CYCLES - 2;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   // Control register accesses
   wire wr_ctrl = io_wr_i && io_addr_i == 6'h1c;
   wire rd_ctrl = io_rd_i && io_addr_i == 6'h1c;
   // Unlock while idle, then program strobe in the same mode
   sequence s_go(m);
      wr_ctrl && io_wdata_i == {2'h0, m, 4'hc} && ready_irq_o ##[1:3] wr_ctrl && io_wdata_i == {2'h0, m, 4'ha};
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_read_stall: assert property (wr_ctrl && io_wdata_i[0] && ready_irq_o
      |=> core_stall_o [*4] ##1 !core_stall_o) else $error("read stall length wrong");
   a_prog_stall: assert property (s_go(2'h0) |=> core_stall_o [*2] ##1 !core_stall_o)
      else $error("program stall length wrong");
   a_busy_irq: assert property (s_go(2'h1) |=> !ready_irq_o [*8])
      else $error("ready request during programming");
   a_atomic_len: assert property (s_go(2'h0) |-> ##A_QUIET !ready_irq_o ##[1:8] ready_irq_o)
      else $error("atomic programming time wrong");
   a_split_len: assert property (s_go(2'h2) |-> ##S_QUIET !ready_irq_o ##[1:8] ready_irq_o)
      else $error("write only programming time wrong");
   a_irq_gate: assert property (ready_irq_o |-> $past(global_irq_en_i))
      else $error("ready request without global enable");
   a_irq_level: assert property (ready_irq_o && global_irq_en_i && !io_wr_i && !$past(io_wr_i) |=> ready_irq_o)
      else $error("ready request dropped while idle");
   a_ctrl_rsvd: assert property ($past(rd_ctrl) |-> io_rdata_o[7:6] == 2'h0)
      else $error("control reserved bits set");
   a_high_rsvd: assert property ($past(io_rd_i && io_addr_i == 6'h1f) |-> io_rdata_o[7:1] == 7'h00)
      else $error("high address reserved bits set");
   a_unlock_expire: assert property (wr_ctrl && io_wdata_i[2:1] == 2'h2 ##5 rd_ctrl |=> !io_rdata_o[2])
      else $error("unlock bit still set");
endmodule

bind nvac_ctrl nvac_checker #(.ATOMIC_CYCLES(ATOMIC_CYCLES), .SPLIT_CYCLES(SPLIT_CYCLES)) u_nvac_checker (
   .clock_i, .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
   .global_irq_en_i, .io_rdata_o, .ready_irq_o, .core_stall_o
);

// >>> verif/nvac_core_model.sv
// Core side bus master for the nvm access controller
// Assumes one-cycle strobes and a core that halts while stall is high
`timescale 1ns/1ps
module nvac_core_model (
   input wire logic clock_i,
   input wire logic core_stall_i,
   input wire logic [7:0] io_rdata_i,
   output logic [5:0] io_addr_o,
   output logic io_wr_o,
   output logic io_rd_o,
   output logic [7:0] io_wdata_o
);
   int n_hang = 0;
   // Bus idle at time zero
   initial begin
      io_addr_o = 6'h00;
      io_wr_o = 1'b0;
      io_rd_o = 1'b0;
      io_wdata_o = 8'h00;
   end
   // One access: wait out a halt, strobe one cycle, take read data next edge
   task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clock_i);
      #1;
      while (core_stall_i !== 1'b0 && n < 8) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (n == 8)
         n_hang++;
      io_addr_o = a;
      io_wdata_o = d;
      io_rd_o = rd;
      io_wr_o = !rd;
      @(posedge clock_i);
      #1;
      io_rd_o = 1'b0;
      io_wr_o = 1'b0;
      // Released lines show the inverse of the last value
      io_addr_o = ~a;
      io_wdata_o = ~d;
      q = 8'h00;
      // Read data stands for the cycle after the strobe edge
      if (rd) begin
         q = io_rdata_i;
         @(posedge clock_i);
      end
   endtask
endmodule

// >>> verif/tb_nvac_ctrl.sv
// Testbench for the nvm access controller
// Assumes short programming counts and the core model as bus master
`timescale 1ns/1ps
module tb_nvac_ctrl;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic global_irq_en_i = 1'b0;
   logic [5:0] io_addr_i;
   logic io_wr_i;
   logic io_rd_i;
   logic [7:0] io_wdata_i;
   logic [7:0] io_rdata_o;
   logic ready_irq_o;
   logic core_stall_o;
   int n_errors = 0;
   int comparisons = 0;
   // Clock of 40 ns
   always #20 clock_i = ~clock_i;
   nvac_ctrl #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) u_nvac_ctrl (
      .clock_i, .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
      .global_irq_en_i, .io_rdata_o, .ready_irq_o, .core_stall_o
   );
   nvac_core_model u_nvac_core_model (
      .clock_i, .core_stall_i(core_stall_o), .io_rdata_i(io_rdata_o), .io_addr_o(io_addr_i),
      .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i)
   );
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_nvac_core_model.access(1'b0, a, d, q);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_nvac_core_model.access(1'b1, a, 8'h00, q);
      check(q, e);
   endtask
   // Poll busy until clear, bounded
   task automatic wait_idle();
      logic [7:0] q;
      int n;
      q = 8'hff;
      for (n = 0; n < 64 && q[1] !== 1'b0; n++) begin
         u_nvac_core_model.access(1'b1, 6'h1c, 8'h00, q);
      end
      if (q[1] !== 1'b0) begin
         n_errors++;
         close_out();
      end
   endtask
   // Unlock then start in mode m, ready enable kept on
   task automatic prog(input logic [1:0] m);
      wr(6'h1c, {2'h0, m, 4'hc});
      wr(6'h1c, {2'h0, m, 4'ha});
   endtask
   // Trigger a read and compare the fetched byte
   task automatic rdm(input logic [7:0] e);
      wr(6'h1c, 8'h09);
      rdc(6'h1d, e);
   endtask
   task automatic pw(input logic [1:0] m, input logic [7:0] d, input logic [7:0] e);
      wr(6'h1d, d);
      prog(m);
      wait_idle();
      rdm(e);
   endtask
   task automatic irq(input logic g, input logic e);
      global_irq_en_i = g;
      repeat (8) @(posedge clock_i);
      #1;
      check({7'h00, ready_irq_o}, {7'h00, e});
   endtask
   task automatic pulse_rst();
      rst_n_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      rdc(6'h1d, 8'h00);
      rdc(6'h1c, 8'h00);
      wr(6'h1e, 8'ha5);
      wr(6'h1f, 8'hff);
      wr(6'h1d, 8'h3c);
      rdc(6'h1f, 8'h01);
      rdc(6'h1e, 8'ha5);
      rdc(6'h1d, 8'h3c);
      wr(6'h1c, 8'h08);
      irq(1'b0, 1'b0);
      irq(1'b1, 1'b1);
      $display("test registers and ready request done");
      prog(2'h0);
      rdc(6'h1c, 8'h0a);
      wr(6'h1c, 8'h38);
      wr(6'h1e, 8'h00);
      rdc(6'h1e, 8'ha5);
      wr(6'h1d, 8'h77);
      wr(6'h1c, 8'h09);
      rdc(6'h1d, 8'h77);
      wait_idle();
      rdc(6'h1c, 8'h08);
      rdm(8'h3c);
      pw(2'h1, 8'h00, 8'hff);
      pw(2'h2, 8'h5a, 8'h5a);
      pw(2'h2, 8'h0f, 8'h0a);
      $display("test programming modes done");
      wr(6'h1c, 8'h0c);
      rdc(6'h1c, 8'h0c);
      rdc(6'h1c, 8'h08);
      repeat (4) @(posedge clock_i);
      wr(6'h1c, 8'h0a);
      rdc(6'h1c, 8'h08);
      prog(2'h3);
      @(posedge clock_i);
      rdc(6'h1c, 8'h38);
      $display("test unlock and reserved mode done");
      prog(2'h1);
      pulse_rst();
      rdc(6'h1c, 8'h12);
      wait_idle();
      rdm(8'hff);
      pulse_rst();
      rdc(6'h1c, 8'h00);
      check(8'(u_nvac_core_model.n_hang), 8'h00);
      $display("test reset during programming done");
      close_out();
   end
endmodule
